// >>> rtl/psb_bus_if.sv
`timescale 1ns/1ps
// Function
// - Pipeline mode issues a write only after write_ready_n low two cycles earlier.
// - Pipeline mode drops the two dummy cycles after each write data.
// - Block write: command, address, then data; strobe held exactly that many cycles.
// - Final block data identifier carries last mark; earlier ones do not.
// - Block writes use the same three write modes as single writes.
// - On ext_request_n, pulse bus_release_n one cycle, then float both buses.
// - While requested, serve external requests only; re-release after completion.
// - Device may request again one cycle after the agent floats the buses.
// - Answer external read with one final response beat, then stay master.
// - Every external read answer has undefined data and error bit 5 set.
// - Null request returns the interface to master state.
// - Any flagged response beat makes the whole response a bus error.
// - Non-coherent block fill sets the line exclusive dirty unconditionally.
// - Write mode from config bits 2-1: 00 legacy, 10 pipeline, 11 reissue.
// - Legacy single write: address, data, two dummy cycles.
// - Command bit 8 marks identifier; type codes read 0, write 2, null 3.
module psb_bus_if
  import psb_pkg::*;
#(
  parameter int unsigned DW = PSB_AD_W,
  parameter int unsigned BLK = PSB_BLK_WORDS
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] interface_config_reg,
  input wire logic wreq_valid,
  input wire psb_wreq_t wreq,
  input wire logic wdat_we,
  input wire logic [$clog2(BLK)-1:0] wdat_idx,
  input wire logic [DW-1:0] wdat,
  output logic wreq_ready,
  input wire logic rd_pending,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data,
  output logic rsp_last,
  output logic rsp_bus_error,
  output logic fill_excl_dirty,
  output logic ext_write_valid,
  output logic [DW-1:0] ext_write_addr,
  output logic [DW-1:0] ext_write_data,
  output logic slave_state,
  input wire logic write_ready_n,
  input wire logic ext_request_n,
  input wire logic inbound_strobe_n,
  output logic outbound_strobe_n,
  output logic bus_release_n,
  input wire psb_beat_t bus_in,
  output psb_beat_t bus_out,
  output logic bus_oe
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [7:0] {
    PSB_S_IDLE = 8'h01,
    PSB_S_ADDR = 8'h02,
    PSB_S_DATA = 8'h04,
    PSB_S_DUMMY = 8'h08,
    PSB_S_REL = 8'h10,
    PSB_S_SLAVE = 8'h20,
    PSB_S_ERSP = 8'h40,
    PSB_S_TURN = 8'h80
  } psb_state_t;

  psb_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic wr_hist_q, wr_hist_d;
  psb_wreq_t cur_q, cur_d;
  logic err_q, err_d;
  logic ewr_addr_q, ewr_addr_d;
  logic [DW-1:0] ewa_q, ewa_d;
  logic [DW-1:0] ewd_q, ewd_d;
  logic ewv_q, ewv_d;
  logic [DW-1:0] rsp_q, rsp_d;
  logic rspv_q, rspv_d;
  logic rspl_q, rspl_d;
  logic rspe_q, rspe_d;
  logic fill_q, fill_d;
  psb_beat_t out_q, out_d;
  logic ostb_q, ostb_d;
  logic rel_q, rel_d;
  logic oe_q, oe_d;
  logic [DW-1:0] buf_rd;
  logic [$clog2(BLK)-1:0] buf_ra;
  logic [1:0] mode;
  logic wr_ok;
  logic in_valid;
  logic in_id;
  logic [2:0] in_type;

  assign mode = interface_config_reg[PSB_CFG_MODE_HI:PSB_CFG_MODE_LO];
  // The take cycle sees the cycle before it, two cycles ahead of the address cycle.
  assign wr_ok = !wr_hist_q;
  assign in_valid = !inbound_strobe_n;
  assign in_id = bus_in.cmd[PSB_CMD_ID_BIT];
  assign in_type = bus_in.cmd[PSB_CMD_TYPE_HI:PSB_CMD_TYPE_LO];
  assign buf_ra = (st_d == PSB_S_DATA) ? cnt_d[$clog2(BLK)-1:0] : '0;

  psb_wbuf #(.DW(DW), .DEPTH(BLK)) u_buf (
    .clk(clk),
    .we(wdat_we),
    .waddr(wdat_idx),
    .wdata(wdat),
    .raddr(buf_ra),
    .rdata(buf_rd)
  );

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_hist_d = write_ready_n;
    cur_d = cur_q;
    err_d = err_q;
    ewr_addr_d = ewr_addr_q;
    ewa_d = ewa_q;
    ewd_d = ewd_q;
    ewv_d = 1'b0;
    rsp_d = rsp_q;
    rspv_d = 1'b0;
    rspl_d = 1'b0;
    rspe_d = 1'b0;
    fill_d = 1'b0;
    out_d = out_q;
    ostb_d = 1'b1;
    rel_d = 1'b1;
    oe_d = oe_q;
    wreq_ready = 1'b0;
    case (st_q)
      PSB_S_IDLE:
      begin
        oe_d = 1'b1;
        if (!ext_request_n || rd_pending)
        begin
          // External requests win; a pending read also hands over the bus.
          st_d = PSB_S_REL;
          rel_d = 1'b0;
        end
        else if (wreq_valid && wr_ok)
        begin
          // Same write-ready gating for single and block writes in every mode.
          wreq_ready = 1'b1;
          cur_d = wreq;
          cnt_d = '0;
          st_d = PSB_S_DATA;
          out_d.ad = wreq.addr;
          out_d.cmd = {1'b0, PSB_TYPE_WRITE, 5'h1f};
          ostb_d = 1'b0;
        end
      end
      PSB_S_DATA:
      begin
        ostb_d = 1'b0;
        out_d.ad = buf_rd;
        out_d.cmd = '0;
        out_d.cmd[PSB_CMD_ID_BIT] = 1'b1;
        out_d.cmd[PSB_ID_LAST_BIT] = (cnt_q + 4'h1 >= cur_q.len) || !cur_q.block;
        cnt_d = cnt_q + 4'h1;
        if (out_d.cmd[PSB_ID_LAST_BIT])
        begin
          cnt_d = '0;
          st_d = (mode == PSB_MODE_LEGACY) ? PSB_S_DUMMY : PSB_S_IDLE;
        end
      end
      PSB_S_DUMMY:
      begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(PSB_LEGACY_DUMMY - 1))
        begin
          st_d = PSB_S_IDLE;
        end
      end
      PSB_S_REL:
      begin
        oe_d = 1'b0;
        err_d = 1'b0;
        ewr_addr_d = 1'b0;
        st_d = PSB_S_SLAVE;
      end
      PSB_S_SLAVE:
      begin
        if (in_valid && !in_id && in_type == PSB_TYPE_READ)
        begin
          st_d = PSB_S_ERSP;
        end
        else if (in_valid && !in_id && in_type == PSB_TYPE_NULL)
        begin
          st_d = PSB_S_TURN;
        end
        else if (in_valid && !in_id && in_type == PSB_TYPE_WRITE)
        begin
          ewr_addr_d = 1'b1;
          ewa_d = bus_in.ad;
        end
        else if (in_valid && in_id && ewr_addr_q)
        begin
          ewd_d = bus_in.ad;
          ewv_d = 1'b1;
          st_d = PSB_S_TURN;
        end
        else if (in_valid && in_id)
        begin
          // Read response beats; any error mark taints the whole response.
          rsp_d = bus_in.ad;
          rspv_d = 1'b1;
          rspl_d = bus_in.cmd[PSB_ID_LAST_BIT];
          err_d = err_q || bus_in.cmd[PSB_ID_ERR_BIT];
          if (bus_in.cmd[PSB_ID_LAST_BIT])
          begin
            rspe_d = err_q || bus_in.cmd[PSB_ID_ERR_BIT];
            fill_d = 1'b1;
            st_d = PSB_S_TURN;
          end
        end
      end
      PSB_S_ERSP:
      begin
        // Nothing inside is externally readable.
        oe_d = 1'b1;
        ostb_d = 1'b0;
        out_d.ad = '0;
        out_d.cmd = '0;
        out_d.cmd[PSB_CMD_ID_BIT] = 1'b1;
        out_d.cmd[PSB_ID_LAST_BIT] = 1'b1;
        out_d.cmd[PSB_ID_RESP_BIT] = 1'b1;
        out_d.cmd[PSB_ID_ERR_BIT] = 1'b1;
        st_d = PSB_S_IDLE;
      end
      PSB_S_TURN:
      begin
        // Wait one cycle after the agent floats before driving again.
        oe_d = 1'b1;
        st_d = PSB_S_IDLE;
      end
      default:
      begin
        st_d = PSB_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q <= PSB_S_IDLE;
      cnt_q <= '0;
      wr_hist_q <= 1'b1;
      cur_q <= '0;
      err_q <= 1'b0;
      ewr_addr_q <= 1'b0;
      ewa_q <= '0;
      ewd_q <= '0;
      ewv_q <= 1'b0;
      rsp_q <= '0;
      rspv_q <= 1'b0;
      rspl_q <= 1'b0;
      rspe_q <= 1'b0;
      fill_q <= 1'b0;
      out_q <= '0;
      ostb_q <= 1'b1;
      rel_q <= 1'b1;
      oe_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_hist_q <= wr_hist_d;
      cur_q <= cur_d;
      err_q <= err_d;
      ewr_addr_q <= ewr_addr_d;
      ewa_q <= ewa_d;
      ewd_q <= ewd_d;
      ewv_q <= ewv_d;
      rsp_q <= rsp_d;
      rspv_q <= rspv_d;
      rspl_q <= rspl_d;
      rspe_q <= rspe_d;
      fill_q <= fill_d;
      out_q <= out_d;
      ostb_q <= ostb_d;
      rel_q <= rel_d;
      oe_q <= oe_d;
    end
  end

  assign outbound_strobe_n = ostb_q;
  assign bus_release_n = rel_q;
  assign bus_out = out_q;
  assign bus_oe = oe_q;
  assign rsp_valid = rspv_q;
  assign rsp_data = rsp_q;
  assign rsp_last = rspl_q;
  assign rsp_bus_error = rspe_q;
  assign fill_excl_dirty = fill_q;
  assign ext_write_valid = ewv_q;
  assign ext_write_addr = ewa_q;
  assign ext_write_data = ewd_q;
  assign slave_state = (st_q == PSB_S_SLAVE);

endmodule : psb_bus_if

// >>> rtl/psb_pkg.sv
package psb_pkg;

  localparam int unsigned PSB_AD_W = 32;
  localparam int unsigned PSB_CMD_W = 9;
  localparam int unsigned PSB_CLK_HZ = 40000000;

  // Command bus layout.
  localparam int unsigned PSB_CMD_ID_BIT = 8;
  localparam int unsigned PSB_CMD_TYPE_HI = 7;
  localparam int unsigned PSB_CMD_TYPE_LO = 5;
  localparam int unsigned PSB_ID_LAST_BIT = 7;
  localparam int unsigned PSB_ID_RESP_BIT = 6;
  localparam int unsigned PSB_ID_ERR_BIT = 5;
  localparam logic [2:0] PSB_TYPE_READ = 3'h0;
  localparam logic [2:0] PSB_TYPE_WRITE = 3'h2;
  localparam logic [2:0] PSB_TYPE_NULL = 3'h3;

  // Write mode field, bits 2-1 of the interface configuration.
  localparam int unsigned PSB_CFG_MODE_HI = 2;
  localparam int unsigned PSB_CFG_MODE_LO = 1;
  localparam logic [1:0] PSB_MODE_LEGACY = 2'h0;
  localparam logic [1:0] PSB_MODE_PIPE = 2'h2;
  localparam logic [1:0] PSB_MODE_REISSUE = 2'h3;
  localparam logic [2:0] PSB_CFG_RST = 3'h0;

  localparam int unsigned PSB_WR_RDY_LEAD = 2;
  localparam int unsigned PSB_LEGACY_DUMMY = 2;
  localparam int unsigned PSB_TAKEOVER_DLY = 2;
  localparam int unsigned PSB_RESUME_DLY = 1;
  localparam int unsigned PSB_BLK_WORDS = 8;

  typedef struct packed {
    logic [PSB_AD_W-1:0] ad;
    logic [PSB_CMD_W-1:0] cmd;
  } psb_beat_t;

  typedef struct packed {
    logic block;
    logic [3:0] len;
    logic [PSB_AD_W-1:0] addr;
  } psb_wreq_t;

endpackage : psb_pkg

// >>> rtl/psb_wbuf.sv
`timescale 1ns/1ps
// Holds the data words of one outgoing write; read data are registered.
module psb_wbuf
  import psb_pkg::*;
#(
  parameter int unsigned DW = PSB_AD_W,
  parameter int unsigned DEPTH = PSB_BLK_WORDS
)
(
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : psb_wbuf

// >>> tb/psb_agent.sv
`timescale 1ns/1ps
// ********
// External agent
// ********
module psb_agent
  import psb_pkg::*;
(
  input wire logic clk,
  input wire logic bus_release_n,
  input wire logic bus_oe,
  output logic write_ready_n,
  output logic ext_request_n,
  output logic inbound_strobe_n,
  output psb_beat_t bus_in
);
  logic drv = 1'b0;
  logic wr_hold = 1'b0;
  psb_beat_t val = '0;
  // A floated bus shows the inverse of its last value, so stale data never look valid.
  assign bus_in = drv ? val : ~val;
  assign write_ready_n = wr_hold;
  initial
  begin
    ext_request_n = 1'b1;
    inbound_strobe_n = 1'b1;
  end
  task automatic beat(input psb_beat_t b);
    val = b;
    drv = 1'b1;
    inbound_strobe_n = 1'b0;
    @(posedge clk);
    #1;
  endtask : beat
  task automatic ext(input logic [2:0] t, input logic [31:0] a, input logic [31:0] d,
    input logic keep);
    int n;
    ext_request_n = 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (bus_release_n && n < 50);
    @(posedge clk);
    #1;
    // A series keeps the request low through the last cycle of this one.
    ext_request_n = !keep;
    beat({a, 1'b0, t, 5'h1f});
    if (t == PSB_TYPE_WRITE)
      beat({d, 9'h19f});
    inbound_strobe_n = 1'b1;
    drv = 1'b0;
  endtask : ext
  task automatic resp(input int n, input int e);
    int k;
    k = 0;
    while (bus_oe && k < 50)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    #1;
    for (k = 0; k < n; k++)
      beat({32'(k), 1'b1, k == n - 1, 1'b1, k == e, 5'h1f});
    inbound_strobe_n = 1'b1;
    drv = 1'b0;
  endtask : resp
endmodule : psb_agent

// >>> tb/psb_bus_if_props.sv
`timescale 1ns/1ps
// ********
// Port checks
// ********
module psb_bus_if_props
  import psb_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] interface_config_reg,
  input wire psb_wreq_t wreq,
  input wire logic wreq_ready,
  input wire logic write_ready_n,
  input wire logic inbound_strobe_n,
  input wire logic outbound_strobe_n,
  input wire logic bus_release_n,
  input wire psb_beat_t bus_in,
  input wire psb_beat_t bus_out,
  input wire logic bus_oe,
  input wire logic slave_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  property p_rel;
    $fell(bus_release_n) |=> bus_release_n ##[0:1] !bus_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("release pulse");
  property p_rdy;
    wreq_ready |-> !$past(write_ready_n);
  endproperty
  a_rdy: assert property (p_rdy) else $error("write without ready");
  property p_adr;
    wreq_ready |=> !outbound_strobe_n && bus_oe && bus_out.cmd[8:5] == {1'b0, PSB_TYPE_WRITE};
  endproperty
  a_adr: assert property (p_adr) else $error("address cycle");
  property p_dat;
    wreq_ready && !wreq.block |=> ##1 !outbound_strobe_n && bus_out.cmd[8:7] == 2'h3;
  endproperty
  a_dat: assert property (p_dat) else $error("single data cycle");
  property p_leg;
    wreq_ready && !wreq.block && interface_config_reg[2:1] == PSB_MODE_LEGACY
      |=> !wreq_ready [*3];
  endproperty
  a_leg: assert property (p_leg) else $error("legacy spacing");
  property p_slv;
    slave_state |-> !wreq_ready;
  endproperty
  a_slv: assert property (p_slv) else $error("write while slave");
  property p_xrd;
    !inbound_strobe_n && slave_state && bus_in.cmd[8:5] == {1'b0, PSB_TYPE_READ}
      |-> ##[1:3] !outbound_strobe_n && bus_out.cmd[8:5] == 4'hf;
  endproperty
  a_xrd: assert property (p_xrd) else $error("external read answer");
  property p_blk;
    wreq_ready && wreq.block && wreq.len == 4'h8
      |=> (!outbound_strobe_n && !bus_out.cmd[7]) [*8] ##1 (!outbound_strobe_n && bus_out.cmd[7]);
  endproperty
  a_blk: assert property (p_blk) else $error("block strobe");
endmodule : psb_bus_if_props
bind psb_bus_if psb_bus_if_props psb_bus_if_props_inst (.clk, .arst_n, .interface_config_reg,
  .wreq, .wreq_ready, .write_ready_n, .inbound_strobe_n, .outbound_strobe_n, .bus_release_n,
  .bus_in, .bus_out, .bus_oe, .slave_state);

// >>> tb/psb_bus_if_test.sv
`timescale 1ns/1ps
// ********
// Bench
// ********
module psb_bus_if_test
  import psb_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, wreq_valid = 1'b0, wdat_we = 1'b0, rd_pending = 1'b0;
  logic [2:0] interface_config_reg = 3'h1, wdat_idx = 3'h0;
  psb_wreq_t wreq = '0;
  logic [31:0] wdat = 32'h0, rsp_data, ext_write_addr, ext_write_data, ewa, ewd;
  logic wreq_ready, rsp_valid, rsp_last, rsp_bus_error, fill_excl_dirty, ext_write_valid;
  logic slave_state, write_ready_n, ext_request_n, inbound_strobe_n, outbound_strobe_n;
  logic bus_release_n, bus_oe, rerr;
  psb_beat_t bus_in, bus_out, ob;
  int mismatches = 0, comparisons = 0, nob = 0, nrsp = 0, nfill = 0, ntake = 0;
  psb_bus_if psb_bus_if_inst (.clk, .arst_n, .interface_config_reg, .wreq_valid, .wreq,
    .wdat_we, .wdat_idx, .wdat, .wreq_ready, .rd_pending, .rsp_valid, .rsp_data, .rsp_last,
    .rsp_bus_error, .fill_excl_dirty, .ext_write_valid, .ext_write_addr, .ext_write_data,
    .slave_state, .write_ready_n, .ext_request_n, .inbound_strobe_n, .outbound_strobe_n,
    .bus_release_n, .bus_in, .bus_out, .bus_oe);
  psb_agent psb_agent_inst (.clk, .bus_release_n, .bus_oe, .write_ready_n, .ext_request_n,
    .inbound_strobe_n, .bus_in);
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (!outbound_strobe_n)
    begin
      ob <= bus_out;
      nob <= nob + 1;
    end
    if (rsp_valid && rsp_last)
      rerr <= rsp_bus_error;
    nrsp <= nrsp + int'(rsp_valid);
    nfill <= nfill + int'(fill_excl_dirty);
    ntake <= ntake + int'(wreq_ready);
    if (ext_write_valid)
    begin
      ewa <= ext_write_addr;
      ewd <= ext_write_data;
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic results;
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic wr(input logic b, input logic [3:0] n, input logic [31:0] a);
    int k;
    for (k = 0; k < n; k++)
    begin
      wdat_we = 1'b1;
      wdat_idx = 3'(k);
      wdat = a + 32'(k);
      @(posedge clk);
      #1;
    end
    wdat_we = 1'b0;
    wreq = '{b, n, a};
    wreq_valid = 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wreq_ready !== 1'b1 && k < 40);
    #1;
    wreq_valid = 1'b0;
    chk("take", 1, 32'(k < 40));
    for (k = 0; k <= n; k++)
    begin
      @(posedge clk);
      chk("strobe", 0, 32'(outbound_strobe_n));
      chk("ad", k > 0 ? a + 32'(k) - 32'h1 : a, bus_out.ad);
      chk("cmd", 32'(k > 0 ? {1'b1, k == n, 2'h0} : {1'b0, PSB_TYPE_WRITE}),
        32'(bus_out.cmd[8:5]));
    end
    #1;
  endtask : wr
  task automatic takes(input int n, output int c, output int g);
    int t;
    wreq = '{1'b0, 4'h1, 32'h40};
    wreq_valid = 1'b1;
    c = 0;
    g = 0;
    t = 0;
    repeat (n)
    begin
      @(posedge clk);
      t++;
      if (wreq_ready === 1'b1)
      begin
        if (c == 1)
          g = t;
        c++;
        t = 0;
      end
    end
    #1;
    wreq_valid = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : takes
  task automatic t_write(input logic [2:0] c);
    int n, g;
    interface_config_reg = c;
    wr(1'b0, 4'h1, 32'h1000);
    wr(1'b1, 4'h8, 32'h2000);
    takes(12, n, g);
    chk("gap", c[2] ? 2 : 4, g);
  endtask : t_write
  task automatic t_ready;
    int n, g;
    psb_agent_inst.wr_hold = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    takes(8, n, g);
    chk("held", 0, n);
    wreq_valid = 1'b1;
    psb_agent_inst.wr_hold = 1'b0;
    @(posedge clk);
    #1;
    psb_agent_inst.wr_hold = 1'b1;
    n = 0;
    for (g = 1; g <= 6; g++)
    begin
      @(posedge clk);
      if (wreq_ready === 1'b1)
      begin
        n++;
        chk("lead", PSB_WR_RDY_LEAD - 1, g);
      end
    end
    #1;
    wreq_valid = 1'b0;
    chk("pulse", 1, n);
    psb_agent_inst.wr_hold = 1'b0;
    wr(1'b0, 4'h1, 32'h3000);
  endtask : t_ready
  task automatic t_ext(input logic [2:0] t, input int nb);
    int n0;
    n0 = nob;
    psb_agent_inst.ext(t, 32'h24, 32'h5a5a, 1'b0);
    repeat (5) @(posedge clk);
    chk("beats", nb, nob - n0);
    chk("oe", 1, 32'(bus_oe));
    chk("slave", 0, 32'(slave_state));
    #1;
  endtask : t_ext
  task automatic t_xread;
    t_ext(PSB_TYPE_READ, 1);
    chk("xrd", 9'h1e0, 32'(ob.cmd & 9'h1e0));
  endtask : t_xread
  task automatic t_xwrite;
    t_ext(PSB_TYPE_WRITE, 0);
    chk("xwa", 32'h24, ewa);
    chk("xwd", 32'h5a5a, ewd);
    t_ext(PSB_TYPE_NULL, 0);
    wr(1'b0, 4'h1, 32'h80);
  endtask : t_xwrite
  task automatic t_series;
    int t0;
    t0 = ntake;
    wreq = '{1'b0, 4'h1, 32'h40};
    wreq_valid = 1'b1;
    psb_agent_inst.ext(PSB_TYPE_NULL, 32'h0, 32'h0, 1'b1);
    psb_agent_inst.ext(PSB_TYPE_WRITE, 32'h38, 32'h0c3c, 1'b0);
    wreq_valid = 1'b0;
    chk("series_take", 0, ntake - t0);
    repeat (3) @(posedge clk);
    chk("series_a", 32'h38, ewa);
    chk("series_d", 32'h0c3c, ewd);
    #1;
  endtask : t_series
  task automatic t_resp(input int e);
    int r0, f0;
    r0 = nrsp;
    f0 = nfill;
    rd_pending = 1'b1;
    psb_agent_inst.resp(8, e);
    rd_pending = 1'b0;
    repeat (4) @(posedge clk);
    chk("rsp", 8, nrsp - r0);
    chk("err", 32'(e >= 0), 32'(rerr));
    chk("fill", 1, nfill - f0);
    #1;
  endtask : t_resp
  initial
  begin
    #100us;
    mismatches++;
    results;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_write(3'h1);
    t_write(3'h5);
    t_write(3'h7);
    t_ready;
    t_xread;
    t_xwrite;
    t_series;
    t_resp(-1);
    t_resp(3);
    results;
  end
endmodule : psb_bus_if_test
